/* File: include/iec_pkg.sv */
package iec_pkg;

    // ********************************************************
    // Register map and control fields
    // ********************************************************
    localparam logic [2:0] ADR_CTRL = 3'h0;
    localparam logic [2:0] ADR_STAT = 3'h1;
    localparam logic [2:0] ADR_DATA = 3'h2;
    localparam logic [2:0] ADR_OWN  = 3'h3;
    localparam logic [2:0] ADR_RATE = 3'h4;
    localparam logic [2:0] ADR_MODE = 3'h5;

    localparam int CTL_FLAG = 7;
    localparam int CTL_ACK  = 6;
    localparam int CTL_STA  = 5;
    localparam int CTL_STO  = 4;
    localparam int CTL_EN   = 2;
    localparam int CTL_IE   = 0;

    localparam logic [7:0] RATE_RST = 8'h10;
    localparam logic [6:0] GC_ADDR  = 7'h00;

    // ********************************************************
    // Status codes
    // ********************************************************
    localparam logic [7:0] CODE_MASK      = 8'hF8;
    localparam logic [7:0] CODE_NONE      = 8'hF8;
    localparam logic [7:0] CODE_BUS_ERR   = 8'h00;
    localparam logic [7:0] CODE_START     = 8'h08;
    localparam logic [7:0] CODE_RSTART    = 8'h10;
    localparam logic [7:0] CODE_MT_AACK   = 8'h18;
    localparam logic [7:0] CODE_MT_ANACK  = 8'h20;
    localparam logic [7:0] CODE_MT_DACK   = 8'h28;
    localparam logic [7:0] CODE_MT_DNACK  = 8'h30;
    localparam logic [7:0] CODE_ARB_LOST  = 8'h38;
    localparam logic [7:0] CODE_MR_AACK   = 8'h40;
    localparam logic [7:0] CODE_MR_ANACK  = 8'h48;
    localparam logic [7:0] CODE_MR_DACK   = 8'h50;
    localparam logic [7:0] CODE_MR_DNACK  = 8'h58;
    localparam logic [7:0] CODE_SR_OWN    = 8'h60;
    localparam logic [7:0] CODE_SR_GC     = 8'h70;
    localparam logic [7:0] CODE_SR_DATA   = 8'h80;
    localparam logic [7:0] CODE_SR_GCDATA = 8'h90;
    localparam logic [7:0] CODE_SR_STOP   = 8'hA0;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_HOLD    = 3'b001,
        ST_START   = 3'b010,
        ST_STOP    = 3'b011,
        ST_BYTE    = 3'b100,
        ST_SLV_RX  = 3'b101,
        ST_SLV_ACK = 3'b110
    } iec_state_t;

    typedef enum logic [1:0] {
        MODE_NONE = 2'b00,
        MODE_MT   = 2'b01,
        MODE_MR   = 2'b10,
        MODE_SR   = 2'b11
    } iec_mode_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } iec_req_t;

    typedef struct packed {
        iec_state_t st;
        iec_mode_t  mode;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [7:0] cnt;
        logic       flag;
        logic [7:0] pend;
        logic [7:0] status;
        logic [1:0] presc;
        logic       irq_en;
        logic       ack_en;
        logic       sta;
        logic       sto;
        logic       en;
        logic [7:0] data;
        logic [6:0] own;
        logic       gc_en;
        logic [7:0] rate;
        logic       master;
        logic       slv;
        logic       gc_hit;
        logic       addr_ph;
        logic       busy;
        logic       scl_m;
        logic       scl_s;
        logic       scl_d;
        logic       sda_m;
        logic       sda_s;
        logic       sda_d;
        logic       scl_oe;
        logic       sda_oe;
        logic       irq;
        logic [7:0] rdata;
    } iec_regs_t;

endpackage

/* File: rtl/iec_top.sv */
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
// Behaviour
// RULE1: Raise event flag on every bus event.
// RULE2: Load status code one cycle after flag.
// RULE3: Status reads no-info code while flag clear.
// RULE4: Hold SCL low while flag set.
// RULE5: Flag after START or repeated START sent.
// RULE6: Flag after address packet sent.
// RULE7: Flag on lost arbitration.
// RULE8: Flag on own or general call match. Code flags write-direction matches only; a read address goes idle.
// RULE9: Flag after data byte received.
// RULE10: Flag on STOP/restart while addressed slave.
// RULE11: Flag and bus error on misplaced START/STOP.
// RULE12: Interrupt only with both enables set.
// RULE13: Writing one clears flag; zero keeps it.
// RULE14: No new bus operation while flag set.
// RULE15: On clear, start the commanded operation.
// RULE16: Transmit status tells slave acknowledge.
// RULE17: One data register for address and data.
// RULE18: No flag after STOP is sent.
// RULE19: Host loads write address before sending.
// RULE20: Host loads registers while flag set.
// RULE21: Host writes control register last.
// RULE22: Host checks status code after events.
// RULE23: Direction/acknowledge bit levels on SDA.
// RULE24: Address direction selects transmit or receive.
// RULE25: Host masks prescaler bits of status.
// RULE26: Reset leaves flag clear, bus released.
// RULE27: Release SCL hold within one cycle.
module iec_top
    import iec_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire iec_req_t   req,
    output logic [7:0]      rdata,
    input  wire logic       global_irq_en,
    output logic            irq,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe
);

    // Synchronisers start at the idle bus level, so no edge follows reset.
    localparam iec_regs_t REGS_RST = '{
        st: ST_IDLE, mode: MODE_NONE, status: CODE_NONE,
        rate: RATE_RST, scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
        sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1, default: '0};

    iec_regs_t  r;
    iec_regs_t  next_r;
    logic       tick;
    logic       rise;
    logic       fall;
    logic       start_det;
    logic       stop_det;
    logic       set_evt;
    logic [7:0] evt_code;
    logic       scl_dr;
    logic       clr;
    logic       tx;
    logic       txbit;
    logic       ack;
    logic       match;

    // ********************************************************
    // Next-state logic
    // ********************************************************
    always_comb begin
        next_r    = r;
        set_evt   = 1'b0;
        evt_code  = r.pend;
        scl_dr    = 1'b0;
        match     = 1'b0;
        ack       = ~r.sda_s; // RULE23
        next_r.scl_m = scl_in;
        next_r.scl_s = r.scl_m;
        next_r.scl_d = r.scl_s;
        next_r.sda_m = sda_in;
        next_r.sda_s = r.sda_m;
        next_r.sda_d = r.sda_s;
        tick      = (r.cnt == 8'h00);
        next_r.cnt = tick ? r.rate : r.cnt - 8'h01;
        rise      = r.scl_s & ~r.scl_d;
        fall      = ~r.scl_s & r.scl_d;
        start_det = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
        stop_det  = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
        tx        = r.addr_ph | (r.mode == MODE_MT);
        if (r.bitn == 4'h8) begin
            txbit = tx ? 1'b1 : ~r.ack_en;
        end else begin
            txbit = tx ? r.data[7] : 1'b1;
        end
        clr = req.wr && (req.addr == ADR_CTRL) && req.wdata[CTL_FLAG];

        if (start_det) begin
            next_r.busy = 1'b1;
        end else if (stop_det) begin
            next_r.busy = 1'b0;
        end

        if (req.wr) begin
            case (req.addr)
                ADR_CTRL: begin
                    next_r.ack_en = req.wdata[CTL_ACK];
                    next_r.sta    = req.wdata[CTL_STA];
                    next_r.sto    = req.wdata[CTL_STO];
                    next_r.en     = req.wdata[CTL_EN];
                    next_r.irq_en = req.wdata[CTL_IE];
                end
                ADR_STAT: next_r.presc = req.wdata[1:0];
                ADR_DATA: next_r.data  = req.wdata; // RULE17
                ADR_OWN: begin
                    next_r.own   = req.wdata[7:1];
                    next_r.gc_en = req.wdata[0];
                end
                ADR_RATE: next_r.rate = req.wdata;
                default: ;
            endcase
        end

        case (r.st)
            ST_IDLE: begin
                if (r.en && r.sta && !r.busy) begin
                    next_r.st = ST_START;
                    next_r.ph = 2'd0;
                end else if (r.en && start_det) begin
                    next_r.st      = ST_SLV_RX;
                    next_r.bitn    = 4'h0;
                    next_r.addr_ph = 1'b1;
                end
            end
            ST_HOLD: begin
                scl_dr = r.master;
                if (!r.flag) begin // RULE14
                    next_r.ph   = 2'd0;
                    next_r.bitn = 4'h0;
                    if (r.master && r.sta) begin // RULE15
                        next_r.st = ST_START;
                    end else if (r.master && r.sto) begin
                        next_r.st = ST_STOP;
                    end else if (r.master) begin
                        next_r.st = ST_BYTE;
                    end else if (r.slv || r.addr_ph) begin
                        next_r.st = ST_SLV_RX;
                    end else if (r.sta && r.en && !r.busy) begin
                        next_r.st = ST_START;
                    end else begin
                        next_r.st = ST_IDLE;
                    end
                end
            end
            ST_START: begin
                case (r.ph)
                    2'd0: begin
                        scl_dr        = r.master;
                        next_r.sda_oe = 1'b0;
                        if (tick) next_r.ph = 2'd1;
                    end
                    2'd1: begin
                        if (tick && r.scl_s) next_r.ph = 2'd2;
                    end
                    2'd2: begin
                        next_r.sda_oe = 1'b1;
                        if (tick) next_r.ph = 2'd3;
                    end
                    default: begin
                        scl_dr = 1'b1;
                        if (tick) begin
                            set_evt = 1'b1; // RULE5
                            evt_code = r.master ? CODE_RSTART
                                                : CODE_START;
                            next_r.master  = 1'b1;
                            next_r.addr_ph = 1'b1;
                            next_r.mode    = MODE_NONE;
                            next_r.st      = ST_HOLD;
                        end
                    end
                endcase
            end
            ST_STOP: begin
                case (r.ph)
                    2'd0: begin
                        scl_dr        = 1'b1;
                        next_r.sda_oe = 1'b1;
                        if (tick) next_r.ph = 2'd1;
                    end
                    2'd1: begin
                        if (tick && r.scl_s) next_r.ph = 2'd2;
                    end
                    default: begin
                        next_r.sda_oe = 1'b0;
                        if (tick) begin
                            next_r.st     = ST_IDLE; // RULE18
                            next_r.master = 1'b0;
                            next_r.sto    = 1'b0;
                            next_r.mode   = MODE_NONE;
                        end
                    end
                endcase
            end
            ST_BYTE: begin
                case (r.ph)
                    2'd0: begin
                        // SDA moves only once SCL is already held low.
                        scl_dr = 1'b1;
                        if (r.scl_oe) begin
                            next_r.sda_oe = ~txbit; // RULE23
                            if (tick) next_r.ph = 2'd1;
                        end
                    end
                    2'd1: begin
                        if (tick && r.scl_s) next_r.ph = 2'd2;
                    end
                    default: begin
                        if (start_det || stop_det) begin
                            set_evt = 1'b1; // RULE11
                            evt_code = CODE_BUS_ERR;
                            next_r.master = 1'b0;
                            next_r.sda_oe = 1'b0;
                            next_r.mode   = MODE_NONE;
                            next_r.st     = ST_HOLD;
                        end else if (tick && r.bitn != 4'h8) begin
                            next_r.data = {r.data[6:0], r.sda_s};
                            next_r.ph   = 2'd0;
                            next_r.bitn = r.bitn + 4'h1;
                            if (tx && txbit && !r.sda_s) begin
                                set_evt = 1'b1; // RULE7
                                evt_code = CODE_ARB_LOST;
                                next_r.master = 1'b0;
                                next_r.sda_oe = 1'b0;
                                next_r.mode   = MODE_NONE;
                                next_r.st     = ST_HOLD;
                            end
                        end else if (tick) begin
                            set_evt = 1'b1; // RULE6 RULE9
                            next_r.addr_ph = 1'b0;
                            next_r.st      = ST_HOLD;
                            next_r.ph      = 2'd0;
                            scl_dr         = 1'b1;
                            if (r.addr_ph && r.data[0]) begin
                                next_r.mode = MODE_MR; // RULE24
                                evt_code = ack ? CODE_MR_AACK
                                               : CODE_MR_ANACK; // RULE16
                            end else if (r.addr_ph) begin
                                next_r.mode = MODE_MT; // RULE24
                                evt_code = ack ? CODE_MT_AACK
                                               : CODE_MT_ANACK;
                            end else if (r.mode == MODE_MT) begin
                                evt_code = ack ? CODE_MT_DACK
                                               : CODE_MT_DNACK;
                            end else begin
                                evt_code = r.ack_en ? CODE_MR_DACK
                                                    : CODE_MR_DNACK;
                            end
                        end
                    end
                endcase
            end
            ST_SLV_RX: begin
                match = (r.data[7:1] == r.own)
                        || (r.gc_en && r.data[7:1] == GC_ADDR);
                if (start_det || stop_det) begin
                    next_r.bitn    = 4'h0;
                    next_r.addr_ph = start_det;
                    if (r.slv) begin
                        set_evt = 1'b1; // RULE10
                        evt_code = CODE_SR_STOP;
                        next_r.slv  = 1'b0;
                        next_r.mode = MODE_NONE;
                        next_r.st   = ST_HOLD;
                    end else if (stop_det) begin
                        next_r.st = ST_IDLE;
                    end
                end else if (rise && r.bitn != 4'h8) begin
                    next_r.data = {r.data[6:0], r.sda_s};
                    next_r.bitn = r.bitn + 4'h1;
                end else if (fall && r.bitn == 4'h8) begin
                    if (r.addr_ph && match && !r.data[0]) begin
                        next_r.sda_oe = 1'b1;
                        next_r.slv    = 1'b1;
                        next_r.mode   = MODE_SR;
                        next_r.gc_hit = (r.data[7:1] != r.own);
                        next_r.st     = ST_SLV_ACK;
                    end else if (r.addr_ph) begin
                        next_r.st = ST_IDLE;
                    end else begin
                        next_r.sda_oe = r.ack_en;
                        next_r.st     = ST_SLV_ACK;
                    end
                end
            end
            ST_SLV_ACK: begin
                if (fall) begin
                    set_evt = 1'b1; // RULE8 RULE9
                    if (r.addr_ph) begin
                        evt_code = r.gc_hit ? CODE_SR_GC : CODE_SR_OWN;
                    end else begin
                        evt_code = r.gc_hit ? CODE_SR_GCDATA
                                            : CODE_SR_DATA;
                    end
                    next_r.sda_oe  = 1'b0;
                    next_r.addr_ph = 1'b0;
                    next_r.bitn    = 4'h0;
                    next_r.st      = ST_HOLD;
                end
            end
            default: next_r.st = ST_IDLE;
        endcase

        // A set in the same cycle as a clear wins.
        next_r.flag = set_evt | (r.flag & ~clr); // RULE1 RULE13
        if (set_evt) next_r.pend = evt_code;
        next_r.status = r.flag ? r.pend : CODE_NONE; // RULE2 RULE3
        next_r.scl_oe = next_r.flag | scl_dr; // RULE4 RULE27
        next_r.irq = r.flag & r.irq_en & global_irq_en; // RULE12

        next_r.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                ADR_CTRL: next_r.rdata = {r.flag, r.ack_en, r.sta,
                                          r.sto, 1'b0, r.en, 1'b0,
                                          r.irq_en};
                ADR_STAT: next_r.rdata = {r.status[7:3], 1'b0,
                                          r.presc};
                ADR_DATA: next_r.rdata = r.data;
                ADR_OWN:  next_r.rdata = {r.own, r.gc_en};
                ADR_RATE: next_r.rdata = r.rate;
                ADR_MODE: next_r.rdata = {6'h00, r.mode};
                default:  next_r.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            r <= REGS_RST; // RULE26
        end else begin
            r <= next_r;
        end
    end

    assign rdata   = r.rdata;
    assign irq     = r.irq;
    assign scl_oe  = r.scl_oe;
    assign sda_oe  = r.sda_oe;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    // ********************************************************
    // Assertions
    // ********************************************************
    a_status_none: assert property (@(posedge sys_clk) disable iff (rst)
        !r.flag |=> r.status == CODE_NONE) // RULE3
        else $error("status not idle code while flag clear");

    a_status_load: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(r.flag) |=> r.status == $past(r.pend)) // RULE2
        else $error("status not loaded after flag rose");

    a_scl_hold: assert property (@(posedge sys_clk) disable iff (rst)
        r.flag |-> scl_oe) // RULE4
        else $error("SCL released while flag set");

    a_flag_clear: assert property (@(posedge sys_clk) disable iff (rst)
        (r.flag && clr && !set_evt) |=> !r.flag) // RULE13
        else $error("flag not cleared by write of one");

    a_flag_keep: assert property (@(posedge sys_clk) disable iff (rst)
        (r.flag && !clr) |=> r.flag) // RULE13
        else $error("flag lost without a clear");

    a_hold_idle: assert property (@(posedge sys_clk) disable iff (rst)
        (r.flag && r.st == ST_HOLD) |=> r.st == ST_HOLD) // RULE14
        else $error("operation began while flag set");

    a_stop_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        ($past(r.st == ST_STOP) && r.st == ST_IDLE && !$past(r.flag))
        |-> !r.flag) // RULE18
        else $error("flag raised after sending stop");

    a_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
        irq |-> $past(r.flag && r.irq_en && global_irq_en)) // RULE12
        else $error("interrupt without both enables");

    a_slave_free: assert property (@(posedge sys_clk) disable iff (rst)
        ($fell(r.flag) && !r.master) |-> !scl_oe) // RULE27
        else $error("slave SCL hold not released");

    a_start_flag: assert property (@(posedge sys_clk) disable iff (rst)
        (r.st == ST_START && r.ph == 2'd3 && tick) |=>
        r.flag ##1 (r.status == CODE_START
                    || r.status == CODE_RSTART)) // RULE5
        else $error("no start event after start sent");

endmodule // iec_top

/* File: verif/iec_slave_model.sv */
`timescale 1ns/1ns
// ****************************************
// Two-wire slave receiver
// ****************************************
module iec_slave_model #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            sda_oe,
    output logic [7:0]      last_byte
);
    logic [7:0] sh;
    int         n;
    logic       act;
    logic       first;

    initial begin
        sda_oe = 1'b0;
        n = 0;
        act = 1'b0;
        first = 1'b0;
        sh = 8'h00;
        last_byte = 8'h00;
    end

    // A falling data line while the clock is high opens a frame.
    always @(negedge sda) if (scl) begin
        n = 0;
        first = 1'b1;
    end
    always @(posedge sda) if (scl) act = 1'b0;
    always @(posedge scl) begin
        if (n < 8) sh = {sh[6:0], sda};
        n = n + 1;
    end
    // Only a matching address and the bytes after it are acknowledged.
    always @(negedge scl) begin
        if (n == 8) begin
            last_byte = sh;
            if (first) act = (sh[7:1] == ADDR);
            first = 1'b0;
            sda_oe = act;
        end else if (n == 9) begin
            sda_oe = 1'b0;
            n = 0;
        end
    end
endmodule // iec_slave_model

/* File: verif/iec_top_test.sv */
`timescale 1ns/1ns
module iec_top_test;
    import iec_pkg::*;
    localparam logic [6:0] SLV = 7'h2A;
    logic        sys_clk;
    logic        rst;
    iec_req_t    req;
    logic [7:0]  rdata;
    logic        global_irq_en;
    logic        irq;
    logic        scl_oe;
    logic        sda_oe;
    logic        scl_out;
    logic        sda_out;
    logic        m_sda_oe;
    logic [7:0]  m_byte;
    wire         scl = !scl_oe;
    wire         sda = !(sda_oe || m_sda_oe);
    logic [8:0]  notes[$];
    logic        pend;
    logic [7:0]  rnd;
    logic [31:0] seed;
    int          miscompares;
    int          samples_checked;
    int          cycles = 0;

    iec_top dut_u (.sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata),
        .global_irq_en(global_irq_en), .irq(irq), .scl_in(scl),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe));
    iec_slave_model #(.ADDR(SLV)) slave_u (.scl(scl), .sda(sda),
        .sda_oe(m_sda_oe), .last_byte(m_byte));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ****************************************
    // Checks and bus cycles
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req <= '0;
    endtask
    // The note's top bit says whether the returned byte is compared.
    task automatic rd(input logic [2:0] a, input logic [8:0] note);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        notes.push_back(note);
        @(posedge sys_clk);
        req <= '0;
        @(negedge sys_clk);
    endtask
    always @(posedge sys_clk) pend <= req.rd;
    always @(negedge sys_clk) if (pend) begin
        if (notes[0][8]) chk_byte(rdata, notes[0][7:0]);
        void'(notes.pop_front());
    end
    task automatic wait_evt(input logic [7:0] code);
        int   i;
        logic f;
        f = 1'b0;
        for (i = 0; i < 400 && !f; i++) begin
            rd(ADR_CTRL, 9'h000);
            f = (rdata[7] === 1'b1);
        end
        chk_bit(f, 1'b1);
        chk_bit(scl_oe, 1'b1);
        chk_bit(irq, global_irq_en);
        rd(ADR_STAT, {1'b1, code});
    endtask
    task automatic step(input logic [7:0] d, input logic [7:0] c,
                        input logic [7:0] code);
        wr(ADR_DATA, d);
        wr(ADR_CTRL, c);
        wait_evt(code);
    endtask
    task automatic stop_bus();
        wr(ADR_CTRL, 8'h95);
        repeat (100) @(posedge sys_clk);
        rd(ADR_CTRL, {1'b1, 8'h05});
        rd(ADR_STAT, {1'b1, CODE_NONE});
        chk_bit(scl_oe, 1'b0);
        chk_bit(sda_oe, 1'b0);
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            $display("[ERR] %0t timeout", $time);
            print_verdict();
        end
    end

    initial begin
        req = '0;
        rst = 1'b1;
        global_irq_en = 1'b0;
        pend = 1'b0;
        seed = 32'h0000_9ce4;
        miscompares = 0;
        samples_checked = 0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        chk_bit(scl_oe, 1'b0);
        chk_bit(sda_oe, 1'b0);
        chk_bit(scl_out | sda_out, 1'b0);
        rd(ADR_STAT, {1'b1, CODE_NONE});
        rd(ADR_CTRL, 9'h100);
        wr(3'h7, 8'hFF);
        rd(3'h7, 9'h100);
        wr(ADR_RATE, 8'h03);
        rd(ADR_RATE, 9'h103);
        wr(ADR_OWN, 8'h66);
        rd(ADR_OWN, 9'h166);
        wr(ADR_STAT, 8'h03);
        rd(ADR_STAT, {1'b1, (CODE_NONE & CODE_MASK) | 8'h03});
        wr(ADR_STAT, 8'h00);
        $display("test registers done");
        @(posedge sys_clk);
        global_irq_en <= 1'b1;
        step(8'h00, 8'hA5, CODE_START);
        wr(ADR_CTRL, 8'h25);
        repeat (20) @(posedge sys_clk);
        rd(ADR_CTRL, {1'b1, 8'hA5});
        rd(ADR_STAT, {1'b1, CODE_START});
        step({SLV, 1'b0}, 8'h85, CODE_MT_AACK);
        chk_byte(m_byte, {SLV, 1'b0});
        rd(ADR_MODE, {1'b1, 6'h00, MODE_MT});
        repeat (3) begin
            seed = lfsr(seed);
            rnd = seed[7:0];
            step(rnd, 8'h85, CODE_MT_DACK);
            chk_byte(m_byte, rnd);
        end
        step(8'h00, 8'hA5, CODE_RSTART);
        step({~SLV, 1'b1}, 8'h85, CODE_MR_ANACK);
        step(8'h00, 8'hA5, CODE_RSTART);
        step({SLV, 1'b1}, 8'h85, CODE_MR_AACK);
        rd(ADR_MODE, {1'b1, 6'h00, MODE_MR});
        step(8'h00, 8'hC5, CODE_MR_DACK);
        rd(ADR_DATA, 9'h1FF);
        stop_bus();
        $display("test interrupt transfer done");
        @(posedge sys_clk);
        global_irq_en <= 1'b0;
        step(8'h00, 8'hA5, CODE_START);
        step({~SLV, 1'b0}, 8'h85, CODE_MT_ANACK);
        stop_bus();
        $display("test polled transfer done");
        print_verdict();
    end
endmodule // iec_top_test
